// ### rtl/sct_pkg.sv
`default_nettype none
package sct_pkg;
  // ascii characters used by the parser and the reply builder
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_TRIG = 8'h3E;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_PERCENT = 8'h25;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_W = 8'h57;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  // field sizes
  localparam int CMD_MAX = 4;
  localparam int LINE_MAX = 20;
  localparam int POS_CHARS = 12;
  localparam int SERIAL_CHARS = 10;
  localparam int VERSION_CHARS = 4;
  localparam int AXES = 4;
  // firmware version text, arbitrary value, first character in the low byte
  localparam logic [8*VERSION_CHARS-1:0] VERSION_TEXT = 32'h3030_2E31;
  // reply kinds
  typedef enum logic [2:0] {
    SCT_POS = 3'h0,
    SCT_AMP = 3'h1,
    SCT_CONV = 3'h2,
    SCT_SERIAL = 3'h3,
    SCT_VERSION = 3'h4,
    SCT_ERRSTAT = 3'h5
  } sct_kind_t;
  // emitter states, gray along idle, load, send
  typedef enum logic [1:0] {
    SCT_IDLE = 2'h0,
    SCT_LOAD = 2'h1,
    SCT_SEND = 2'h3
  } sct_state_t;
  // per-axis sensor readings
  typedef struct packed {
    logic [6:0] amplitude;
    logic signed [11:0] conv_a;
    logic signed [11:0] conv_b;
  } sct_sense_t;
  // one reply line under construction
  typedef struct packed {
    logic [4:0] len;
    logic [8*LINE_MAX-1:0] text;
  } sct_line_t;
  // decimal digits with leading-zero suppression count
  typedef struct packed {
    logic [2:0] cnt;
    logic [15:0] digit;
  } sct_dec_t;
endpackage : sct_pkg
`default_nettype wire

// ### rtl/sct_buf2.sv
`default_nettype none
module sct_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0] count;
  logic [1:0] next_count;
  logic [W-1:0] head;
  logic [W-1:0] next_head;
  logic [W-1:0] tail;
  logic [W-1:0] next_tail;
  logic push;
  logic pop;

  // handshakes: honest full and empty
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = head;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // head always holds the oldest word
  always_comb begin
    next_count = count;
    next_head = head;
    next_tail = tail;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
    if (pop) begin
      next_head = (count == 2'h2) ? tail : in_data;
    end else if (push && count == 2'h0) begin
      next_head = in_data;
    end
    if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
      next_tail = in_data;
    end
  end

  // storage registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 2'h0;
      head <= '0;
      tail <= '0;
    end else begin
      count <= next_count;
      head <= next_head;
      tail <= next_tail;
    end
  end
endmodule : sct_buf2
`default_nettype wire

// ### rtl/sct_service.sv
// What this block does
// - factory reset command pulses default restore
// - serial query replies stored stage serial
// - unknown command sets sticky flag; query clears
// - amplitude query: letter, percent, percent sign
// - conversion query: letter, signed a, b
// - trigger sends lines for displayed axes
// - polled position lines start with space
// - triggered position lines start with greater-than
// - reply lines end with CR LF
// - command letters accepted in either case
// - asterisk addresses all active axes
`default_nettype none
module sct_service (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // received command bytes
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  // reply bytes
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // trigger sources, active high levels
  input wire logic trig_key,
  input wire logic trig_foot,
  // axis data
  input wire logic [1:0] active_axis_last,
  input wire logic [sct_pkg::AXES*8*sct_pkg::POS_CHARS-1:0] pos_text,
  input wire sct_pkg::sct_sense_t [sct_pkg::AXES-1:0] sense,
  input wire logic [8*sct_pkg::SERIAL_CHARS-1:0] stage_serial,
  // status and actions
  output logic factory_reset_cmd,
  output logic error_flag
);
  sct_pkg::sct_state_t state, next_state;
  sct_pkg::sct_kind_t kind, next_kind;
  sct_pkg::sct_line_t line, next_line, composed;
  logic [8*sct_pkg::CMD_MAX-1:0] cmd, next_cmd;
  logic [2:0] cmd_cnt, next_cmd_cnt;
  logic cmd_long, next_cmd_long;
  logic trig_mode, next_trig_mode;
  logic [1:0] cur_axis, next_cur_axis;
  logic [1:0] last_axis, next_last_axis;
  logic [4:0] idx, next_idx;
  logic err, next_err;
  logic err_snap, next_err_snap;
  logic trig_pend, next_trig_pend;
  logic key_q, foot_q;
  logic factory, next_factory;
  logic [7:0] rx_up;
  logic [7:0] c0, c1, c2;
  logic fifo_valid, fifo_ready;
  logic [7:0] fifo_data;

  // append one character to a line
  function automatic sct_pkg::sct_line_t put(sct_pkg::sct_line_t l, logic [7:0] ch);
    sct_pkg::sct_line_t r;
    r = l;
    r.text[8*l.len +: 8] = ch;
    r.len = l.len + 5'h1;
    return r;
  endfunction : put

  // decimal digits of a value below 10000
  function automatic sct_pkg::sct_dec_t to_dec(logic [13:0] v);
    sct_pkg::sct_dec_t d;
    logic [13:0] q;
    q = v / 14'd1000;
    d.digit[15:12] = q[3:0];
    q = (v / 14'd100) % 14'd10;
    d.digit[11:8] = q[3:0];
    q = (v / 14'd10) % 14'd10;
    d.digit[7:4] = q[3:0];
    q = v % 14'd10;
    d.digit[3:0] = q[3:0];
    d.cnt = (v >= 14'd1000) ? 3'h4 : (v >= 14'd100) ? 3'h3 : (v >= 14'd10) ? 3'h2 : 3'h1;
    return d;
  endfunction : to_dec

  // append a number without leading zeros
  function automatic sct_pkg::sct_line_t put_num(sct_pkg::sct_line_t l, logic [13:0] v);
    sct_pkg::sct_line_t r;
    sct_pkg::sct_dec_t d;
    r = l;
    d = to_dec(v);
    for (int k = 3; k >= 0; k--) begin
      if (k < int'(d.cnt)) begin
        r = put(r, sct_pkg::CH_ZERO | {4'h0, d.digit[4*k +: 4]});
      end
    end
    return r;
  endfunction : put_num

  // append a sign and magnitude of a conversion result
  function automatic sct_pkg::sct_line_t put_signed(sct_pkg::sct_line_t l, logic signed [11:0] v);
    sct_pkg::sct_line_t r;
    logic [12:0] mag;
    mag = v[11] ? 13'(-$signed({v[11], v})) : {1'b0, v};
    r = put(l, v[11] ? sct_pkg::CH_MINUS : sct_pkg::CH_PLUS);
    return put_num(r, {1'b0, mag});
  endfunction : put_signed

  // axis index to letter
  function automatic logic [7:0] axis_letter(logic [1:0] a);
    case (a)
      2'h0: return sct_pkg::CH_X;
      2'h1: return sct_pkg::CH_Y;
      2'h2: return sct_pkg::CH_Z;
      default: return sct_pkg::CH_W;
    endcase
  endfunction : axis_letter

  // upper-case the incoming byte
  assign rx_up = (rx_data >= sct_pkg::CH_LOWER_A && rx_data <= sct_pkg::CH_LOWER_Z) ?
                 (rx_data & ~sct_pkg::CASE_BIT) : rx_data;
  assign c0 = cmd[7:0];
  assign c1 = cmd[15:8];
  assign c2 = cmd[23:16];
  assign rx_ready = (state == sct_pkg::SCT_IDLE);
  assign factory_reset_cmd = factory;
  assign error_flag = err;

  // build the line for the current kind and axis
  always_comb begin
    composed = '0;
    case (kind)
      sct_pkg::SCT_POS: begin
        composed = put(composed, trig_mode ? sct_pkg::CH_TRIG : sct_pkg::CH_SPACE);
        composed = put(composed, axis_letter(cur_axis));
        composed = put(composed, sct_pkg::CH_SPACE);
        for (int j = 0; j < sct_pkg::POS_CHARS; j++) begin
          composed = put(composed, pos_text[8*(sct_pkg::POS_CHARS*int'(cur_axis) + j) +: 8]);
        end
      end
      sct_pkg::SCT_AMP: begin
        composed = put(composed, axis_letter(cur_axis));
        composed = put(composed, sct_pkg::CH_SPACE);
        composed = put_num(composed, {7'h00, sense[cur_axis].amplitude});
        composed = put(composed, sct_pkg::CH_SPACE);
        composed = put(composed, sct_pkg::CH_PERCENT);
      end
      sct_pkg::SCT_CONV: begin
        composed = put(composed, axis_letter(cur_axis));
        composed = put(composed, sct_pkg::CH_SPACE);
        composed = put_signed(composed, sense[cur_axis].conv_a);
        composed = put(composed, sct_pkg::CH_SPACE);
        composed = put_signed(composed, sense[cur_axis].conv_b);
      end
      sct_pkg::SCT_SERIAL: begin
        for (int j = 0; j < sct_pkg::SERIAL_CHARS; j++) begin
          composed = put(composed, stage_serial[8*j +: 8]);
        end
      end
      sct_pkg::SCT_VERSION: begin
        for (int j = 0; j < sct_pkg::VERSION_CHARS; j++) begin
          composed = put(composed, sct_pkg::VERSION_TEXT[8*j +: 8]);
        end
      end
      default: begin
        composed = put(composed, err_snap ? sct_pkg::CH_ONE : sct_pkg::CH_ZERO);
      end
    endcase
    composed = put(composed, sct_pkg::CH_CR);
    composed = put(composed, sct_pkg::CH_LF);
  end

  // parser, flags and line emitter next values
  always_comb begin
    logic start;
    logic unknown;
    logic all_ax;
    logic [1:0] ax;
    logic ax_ok;
    logic [7:0] ac;
    start = 1'b0;
    unknown = 1'b0;
    all_ax = 1'b0;
    ax = 2'h0;
    ax_ok = 1'b0;
    ac = 8'h00;
    next_state = state;
    next_kind = kind;
    next_line = line;
    next_cmd = cmd;
    next_cmd_cnt = cmd_cnt;
    next_cmd_long = cmd_long;
    next_trig_mode = trig_mode;
    next_cur_axis = cur_axis;
    next_last_axis = last_axis;
    next_idx = idx;
    next_err_snap = err_snap;
    next_factory = 1'b0;
    next_trig_pend = trig_pend | (trig_key & ~key_q) | (trig_foot & ~foot_q);
    fifo_valid = 1'b0;
    fifo_data = line.text[8*idx +: 8];
    case (state)
      sct_pkg::SCT_IDLE: begin
        if (rx_valid && rx_up != sct_pkg::CH_CR) begin
          if (cmd_cnt == 3'(sct_pkg::CMD_MAX)) begin
            next_cmd_long = 1'b1;
          end else begin
            next_cmd[8*cmd_cnt +: 8] = rx_up;
            next_cmd_cnt = cmd_cnt + 3'h1;
          end
        end else if (rx_valid) begin
          next_cmd = '0;
          next_cmd_cnt = 3'h0;
          next_cmd_long = 1'b0;
          // axis selector: in the first byte for polls, in the second otherwise
          ac = (cmd_cnt == 3'h1) ? c0 : c1;
          case (ac)
            sct_pkg::CH_X: ax = 2'h0;
            sct_pkg::CH_Y: ax = 2'h1;
            sct_pkg::CH_Z: ax = 2'h2;
            default: ax = 2'h3;
          endcase
          all_ax = (ac == sct_pkg::CH_STAR);
          ax_ok = all_ax || ((ac == sct_pkg::CH_X || ac == sct_pkg::CH_Y || ac == sct_pkg::CH_Z ||
                  ac == sct_pkg::CH_W) && ax <= active_axis_last);
          next_trig_mode = 1'b0;
          next_cur_axis = all_ax ? 2'h0 : ax;
          next_last_axis = all_ax ? active_axis_last : ax;
          if (cmd_long) begin
            unknown = 1'b1;
          end else if (cmd_cnt == 3'h0) begin
            unknown = 1'b0;
          end else if (cmd_cnt == 3'h1 && ax_ok) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_POS;
          end else if (cmd_cnt == 3'h3 && c0 == sct_pkg::CH_S && c1 == sct_pkg::CH_R &&
                       c2 == sct_pkg::CH_PLUS) begin
            next_factory = 1'b1;
          end else if (cmd_cnt == 3'h2 && c0 == sct_pkg::CH_S && c1 == sct_pkg::CH_V) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_VERSION;
          end else if (cmd_cnt == 3'h2 && c0 == sct_pkg::CH_S && c1 == sct_pkg::CH_N) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_SERIAL;
          end else if (cmd_cnt == 3'h2 && c0 == sct_pkg::CH_M && c1 == sct_pkg::CH_QUERY) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_ERRSTAT;
            next_err_snap = err;
          end else if (cmd_cnt == 3'h2 && c0 == sct_pkg::CH_A && ax_ok) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_AMP;
          end else if (cmd_cnt == 3'h2 && c0 == sct_pkg::CH_C && ax_ok) begin
            start = 1'b1;
            next_kind = sct_pkg::SCT_CONV;
          end else begin
            unknown = 1'b1;
          end
          if (start && (next_kind != sct_pkg::SCT_POS && next_kind != sct_pkg::SCT_AMP &&
                        next_kind != sct_pkg::SCT_CONV)) begin
            next_cur_axis = 2'h0;
            next_last_axis = 2'h0;
          end
        end else if (trig_pend) begin
          start = 1'b1;
          next_trig_pend = 1'b0 | (trig_key & ~key_q) | (trig_foot & ~foot_q);
          next_kind = sct_pkg::SCT_POS;
          next_trig_mode = 1'b1;
          next_cur_axis = 2'h0;
          next_last_axis = active_axis_last;
        end
        if (start) begin
          next_state = sct_pkg::SCT_LOAD;
        end
      end
      sct_pkg::SCT_LOAD: begin
        next_line = composed;
        next_idx = 5'h0;
        next_state = sct_pkg::SCT_SEND;
      end
      sct_pkg::SCT_SEND: begin
        fifo_valid = 1'b1;
        if (fifo_ready) begin
          next_idx = idx + 5'h1;
          if (idx == line.len - 5'h1) begin
            if (cur_axis == last_axis) begin
              next_state = sct_pkg::SCT_IDLE;
            end else begin
              next_cur_axis = cur_axis + 2'h1;
              next_state = sct_pkg::SCT_LOAD;
            end
          end
        end
      end
      default: begin
        next_state = sct_pkg::SCT_IDLE;
      end
    endcase
    // a new unknown command wins over the clear by the status query
    next_err = (err & ~(start && next_kind == sct_pkg::SCT_ERRSTAT && state == sct_pkg::SCT_IDLE &&
                rx_valid)) | unknown;
  end

  // state registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sct_pkg::SCT_IDLE;
      kind <= sct_pkg::SCT_POS;
      line <= '0;
      cmd <= '0;
      cmd_cnt <= 3'h0;
      cmd_long <= 1'b0;
      trig_mode <= 1'b0;
      cur_axis <= 2'h0;
      last_axis <= 2'h0;
      idx <= 5'h0;
      err <= 1'b0;
      err_snap <= 1'b0;
      trig_pend <= 1'b0;
      key_q <= 1'b0;
      foot_q <= 1'b0;
      factory <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      line <= next_line;
      cmd <= next_cmd;
      cmd_cnt <= next_cmd_cnt;
      cmd_long <= next_cmd_long;
      trig_mode <= next_trig_mode;
      cur_axis <= next_cur_axis;
      last_axis <= next_last_axis;
      idx <= next_idx;
      err <= next_err;
      err_snap <= next_err_snap;
      trig_pend <= next_trig_pend;
      key_q <= trig_key;
      foot_q <= trig_foot;
      factory <= next_factory;
    end
  end

  // two-entry buffer toward the serial transmitter
  sct_buf2 #(
    .W(8)
  ) u_txbuf (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule : sct_service
`default_nettype wire

// ### dv/sct_service_chk.sv
`default_nettype none
module sct_service_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // command and reply streams
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  // triggers and axis data
  input wire logic trig_key,
  input wire logic trig_foot,
  input wire logic [1:0] active_axis_last,
  input wire logic [sct_pkg::AXES*8*sct_pkg::POS_CHARS-1:0] pos_text,
  input wire sct_pkg::sct_sense_t [sct_pkg::AXES-1:0] sense,
  input wire logic [8*sct_pkg::SERIAL_CHARS-1:0] stage_serial,
  // status
  input wire logic factory_reset_cmd,
  input wire logic error_flag
);
  logic take_cr;
  logic cr_q;
  logic lf_due;
  logic [7:0] up;
  logic [31:0] hs;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // carriage return taken, and the taken byte folded to upper case
  assign take_cr = rx_valid && rx_ready && rx_data == sct_pkg::CH_CR;
  assign up = (rx_data >= sct_pkg::CH_LOWER_A && rx_data <= sct_pkg::CH_LOWER_Z) ?
    (rx_data & ~sct_pkg::CASE_BIT) : rx_data;
  // last four taken bytes, and whether the next reply byte must be a line feed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs <= {4{sct_pkg::CH_CR}};
      cr_q <= 1'b0;
      lf_due <= 1'b0;
    end else begin
      if (rx_valid && rx_ready) begin
        hs <= {hs[23:0], up};
      end
      cr_q <= take_cr;
      if (tx_valid && tx_ready) begin
        lf_due <= tx_data == sct_pkg::CH_CR;
      end
    end
  end
  // command lines ending at this edge; the sn and m? lines also need the reply buffer empty
  sequence sn_cr;
    take_cr && !tx_valid && hs[23:0] == {sct_pkg::CH_CR, sct_pkg::CH_S, sct_pkg::CH_N};
  endsequence
  sequence mq_cr;
    take_cr && !tx_valid && hs[23:0] == {sct_pkg::CH_CR, sct_pkg::CH_M, sct_pkg::CH_QUERY};
  endsequence
  sequence sr_cr;
    take_cr && hs == {sct_pkg::CH_CR, sct_pkg::CH_S, sct_pkg::CH_R, sct_pkg::CH_PLUS};
  endsequence
  a_sr_pulse: assert property (sr_cr |=> factory_reset_cmd)
    else $error("reset command gave no pulse");
  a_pulse_once: assert property (factory_reset_cmd |-> cr_q ##1 !factory_reset_cmd)
    else $error("stray or long reset pulse");
  a_serial_walk: assert property (
    sn_cr |=> !rx_ready ##2 (tx_valid && tx_data == stage_serial[7:0]))
    else $error("serial reply late or wrong");
  a_err_set: assert property (take_cr && hs[7:0] == 8'h51 |=> error_flag)
    else $error("unknown command not flagged");
  a_err_hold: assert property (error_flag && !take_cr |=> error_flag)
    else $error("error flag dropped");
  a_err_clear: assert property (mq_cr |=> !error_flag)
    else $error("status query left flag set");
  a_status_reply: assert property (
    mq_cr |-> ##3 (tx_valid && tx_data == ($past(error_flag, 3) ? sct_pkg::CH_ONE : sct_pkg::CH_ZERO)))
    else $error("status reply wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte lost under stall");
  a_line_end: assert property (tx_valid && lf_due |-> tx_data == sct_pkg::CH_LF)
    else $error("carriage return not followed by line feed");
  a_trig_lead: assert property (
    $rose(trig_foot) && !trig_key && rx_ready && !rx_valid && !tx_valid
    |-> ##[1:8] (tx_valid && tx_data == sct_pkg::CH_TRIG))
    else $error("trigger line lead missing");
endmodule : sct_service_chk
bind sct_service sct_service_chk u_chk (.ref_clk, .arst_n, .rx_valid, .rx_ready, .rx_data,
  .tx_valid, .tx_ready, .tx_data, .trig_key, .trig_foot, .active_axis_last, .pos_text,
  .sense, .stage_serial, .factory_reset_cmd, .error_flag);
`default_nettype wire

// ### dv/sct_host_model.sv
`default_nettype none
module sct_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // command bytes towards the block
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // reply bytes from the block
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  bit slow = 0;
  int n = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // one byte, held until taken, then the line shows the inverse
  task automatic put(input logic [7:0] b);
    int k;
    k = 0;
    @(negedge ref_clk);
    rx_valid = 1'b1;
    rx_data = b;
    do begin
      @(posedge ref_clk);
      k++;
    end while (rx_ready !== 1'b1 && k < 300);
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data = ~b;
  endtask : put
  // command text closed by carriage return
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(sct_pkg::CH_CR);
  endtask : send
  // slow host accepts one byte in three
  always @(negedge ref_clk) begin
    n++;
    tx_ready <= !slow || n % 3 == 0;
  end
  // collect reply bytes
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule : sct_host_model
`default_nettype wire

// ### dv/sct_service_tb.sv
`default_nettype none
module sct_service_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic arst_n;
  logic rx_valid;
  logic rx_ready;
  logic [7:0] rx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;
  logic trig_key;
  logic trig_foot;
  logic [1:0] active_axis_last;
  logic [sct_pkg::AXES*8*sct_pkg::POS_CHARS-1:0] pos_text;
  sct_pkg::sct_sense_t [sct_pkg::AXES-1:0] sense;
  logic [8*sct_pkg::SERIAL_CHARS-1:0] stage_serial;
  logic factory_reset_cmd;
  logic error_flag;
  int bad_count = 0;
  int checked = 0;
  int pulses = 0;
  string pos_s[4] = '{"+0001.250 mm", "-0002.500 mm", "+0003.750 mm", "-0004.000 mm"};
  sct_service DUT (.ref_clk, .arst_n, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready,
    .tx_data, .trig_key, .trig_foot, .active_axis_last, .pos_text, .sense, .stage_serial,
    .factory_reset_cmd, .error_flag);
  sct_host_model host (.ref_clk, .arst_n, .rx_valid, .rx_ready, .rx_data, .tx_valid,
    .tx_ready, .tx_data);
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // count reset pulses
  always @(posedge ref_clk) begin
    if (factory_reset_cmd === 1'b1) pulses++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] pop();
    if (host.got.size() == 0) return 8'hFF;
    return host.got.pop_front();
  endfunction : pop
  // wait for one whole reply line and compare it
  task automatic expect_line(input string s);
    int k;
    k = 0;
    while (host.got.size() < s.len() + 2 && k < 3000) begin
      @(posedge ref_clk);
      k++;
    end
    for (int i = 0; i < s.len(); i++) check(pop(), s[i]);
    check(pop(), sct_pkg::CH_CR);
    check(pop(), sct_pkg::CH_LF);
  endtask : expect_line
  task automatic no_reply();
    repeat (12) @(posedge ref_clk);
    check(8'(host.got.size()), 8'h00);
  endtask : no_reply
  task automatic t_reset_cmd();
    pulses = 0;
    host.send("sr+");
    no_reply();
    check(8'(pulses), 8'h01);
    $display("factory reset test done");
  endtask : t_reset_cmd
  task automatic t_serial();
    @(negedge ref_clk);
    stage_serial = {"9876543-BA"};
    host.send("sn");
    expect_line("AB-3456789");
    // version text is the arbitrary firmware tag of the package
    host.send("sv");
    expect_line("1.00");
    $display("serial test done");
  endtask : t_serial
  task automatic t_status();
    // a bare carriage return is ignored and sets no flag
    host.send("");
    no_reply();
    host.send("M?");
    expect_line("0");
    // a command longer than four characters is unknown
    host.send("snxyz");
    no_reply();
    check(8'(error_flag), 8'h01);
    host.send("M?");
    expect_line("1");
    host.send("Qq");
    no_reply();
    check(8'(error_flag), 8'h01);
    host.send("m?");
    expect_line("1");
    check(8'(error_flag), 8'h00);
    $display("status test done");
  endtask : t_status
  task automatic t_amp();
    @(negedge ref_clk);
    active_axis_last = 2'h3;
    sense[0].amplitude = 7'h41;
    sense[1].amplitude = 7'h64;
    sense[2].amplitude = 7'h00;
    sense[3].amplitude = 7'h07;
    host.send("A*");
    expect_line("X 65 %");
    expect_line("Y 100 %");
    expect_line("Z 0 %");
    expect_line("W 7 %");
    @(negedge ref_clk);
    active_axis_last = 2'h1;
    host.send("az");
    no_reply();
    check(8'(error_flag), 8'h01);
    host.send("M?");
    expect_line("1");
    $display("amplitude test done");
  endtask : t_amp
  task automatic t_conv();
    @(negedge ref_clk);
    active_axis_last = 2'h3;
    sense[0].conv_a = -12'sd1400;
    sense[0].conv_b = 12'sd550;
    sense[3].conv_a = 12'sd0;
    sense[3].conv_b = -12'sd1;
    host.send("cx");
    expect_line("X -1400 +550");
    host.send("CW");
    expect_line("W +0 -1");
    $display("conversion test done");
  endtask : t_conv
  task automatic t_poll_trig();
    @(negedge ref_clk);
    active_axis_last = 2'h1;
    host.send("*");
    expect_line({" X ", pos_s[0]});
    expect_line({" Y ", pos_s[1]});
    @(negedge ref_clk);
    trig_key = 1'b1;
    repeat (3) @(negedge ref_clk);
    trig_key = 1'b0;
    expect_line({">X ", pos_s[0]});
    expect_line({">Y ", pos_s[1]});
    // slow host stalls the reply buffer during a four-axis burst
    @(negedge ref_clk);
    active_axis_last = 2'h3;
    host.slow = 1;
    repeat (2) @(negedge ref_clk);
    trig_foot = 1'b1;
    repeat (3) @(negedge ref_clk);
    trig_foot = 1'b0;
    expect_line({">X ", pos_s[0]});
    expect_line({">Y ", pos_s[1]});
    expect_line({">Z ", pos_s[2]});
    expect_line({">W ", pos_s[3]});
    host.slow = 0;
    $display("position and trigger test done");
  endtask : t_poll_trig
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // reset, axis text, then the scenarios
  initial begin
    arst_n = 1'b0;
    trig_key = 1'b0;
    trig_foot = 1'b0;
    active_axis_last = 2'h3;
    sense = '0;
    stage_serial = '0;
    for (int a = 0; a < 4; a++) begin
      for (int j = 0; j < 12; j++) pos_text[8*(12*a+j)+:8] = pos_s[a][j];
    end
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_reset_cmd();
    t_serial();
    t_status();
    t_amp();
    t_conv();
    t_poll_trig();
    tally_and_finish();
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : sct_service_tb
`default_nettype wire
